// ### rtl/fetch_pipeline_regs.vh
// Constants for the instruction fetch front end
`ifndef FETCH_PIPELINE_REGS_VH
`define FETCH_PIPELINE_REGS_VH
`define ADDR_WIDTH 32
`define INSTR_WIDTH 32
`define RESET_FETCH_ADDR 32'h0000_0000
`define FETCH_STEP 32'h0000_0004
`define BUF_DEPTH 10
`define BRANCH_CACHE_ENTRIES 8
`define PRED_TABLE_ENTRIES 128
`define RETURN_STACK_ENTRIES 4
`define PRED_STRONG_NT 2'h0
`define PRED_WEAK_NT 2'h1
`define PRED_WEAK_T 2'h2
`define PRED_STRONG_T 2'h3
`define CLASS_SEQ 3'h0
`define CLASS_COND 3'h1
`define CLASS_UNCOND 3'h2
`define CLASS_CALL 3'h3
`define CLASS_RET 3'h4
`define OPC_COND 8'h60
`define OPC_UNCOND 8'h61
`define OPC_CALL 8'h62
`define OPC_RET 8'h63
`endif

// ### rtl/instr_fetch_branch_predictor.v
// Instruction fetch front end with two-level branch prediction
// Summary of operation
// (RULE1) Fetch runs address generation, fetch one, fetch two, early decode, then a buffer stage.
// (RULE2) Fetch one starts the bus access and fetch two completes it next cycle.
// (RULE3) Early decode produces decode signals that travel with each instruction.
// (RULE4) A ten-entry FIFO lets fetch run ahead of the execution pipeline. The code stalls fetch at eight entries, so at most eight are filled.
// (RULE5) Decode-stage registers load from the buffer, or from early decode when it is empty.
// (RULE6) An 8-entry direct-mapped branch cache holds a 2-bit prediction state per entry.
// (RULE7) Each cache entry pairs a branch address with its target address.
// (RULE8) A taken cache hit at fetch one redirects address generation to the target.
// (RULE9) Correctly predicted taken conditional branches are folded out of the stream. The code folds only those that hit taken in the branch cache.
// (RULE10) A cache miss on a conditional branch consults a 128-entry prediction table.
// (RULE11) Early decode computes the target of a predicted taken branch and redirects.
// (RULE12) Unconditional branches, jumps and calls redirect to a computed target.
// (RULE13) A four-entry return stack: calls push, returns pop the predicted address.
// (RULE14) Fetch addresses are 32 bits wide.
// (RULE15) On resolution the 2-bit state steps toward the outcome and saturates.
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pipeline_regs.vh"
module instr_fetch_branch_predictor #(
  parameter DEPTH = `BUF_DEPTH
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Local instruction bus
  output reg [31:0] busAddr,
  output wire busReq,
  input wire [31:0] busData,
  // Decode stage: two instruction slots
  output reg [31:0] instr0,
  output reg [31:0] pc0,
  output reg [2:0] class0,
  output reg taken0,
  output reg valid0,
  output reg [31:0] instr1,
  output reg [31:0] pc1,
  output reg [2:0] class1,
  output reg taken1,
  output reg valid1,
  input wire [1:0] decodeTake,
  // Branch resolution from execution
  input wire resolveValid,
  input wire [31:0] resolvePc,
  input wire [31:0] resolveTarget,
  input wire resolveTaken,
  input wire resolveMispredict,
  // Status
  output wire bufFull,
  output wire bufEmpty
);
  // (RULE14) 32-bit fetch address
  reg [31:0] agAddr_reg;
  reg s1Valid_reg, s2Valid_reg, edValid_reg;
  reg [31:0] s1Addr_reg, s2Addr_reg, edAddr_reg, edInstr_reg;
  reg [2:0] edClass_reg;
  reg edTaken_reg, s2Hit_reg, edHit_reg, s2Live_reg;
  reg [31:0] s2Hold_reg;
  reg [31:0] bcBranch [0:`BRANCH_CACHE_ENTRIES-1];
  reg [31:0] bcTarget [0:`BRANCH_CACHE_ENTRIES-1];
  reg [1:0] bcState [0:`BRANCH_CACHE_ENTRIES-1];
  reg [`BRANCH_CACHE_ENTRIES-1:0] bcValid;
  reg [1:0] ptState [0:`PRED_TABLE_ENTRIES-1];
  reg [31:0] rstack [0:`RETURN_STACK_ENTRIES-1];
  reg [1:0] rsTop_reg;
  reg [2:0] rsCount_reg;
  reg [31:0] bufInstr [0:DEPTH-1];
  reg [31:0] bufPc [0:DEPTH-1];
  reg [2:0] bufClass [0:DEPTH-1];
  reg bufTaken [0:DEPTH-1];
  reg [3:0] bufRd_reg, bufWr_reg, bufCnt_reg;
  integer i;

  // Branch cache lookup at fetch one
  wire [2:0] bcIdx = s1Addr_reg[4:2];
  wire bcHit = s1Valid_reg && bcValid[bcIdx] && bcBranch[bcIdx] == s1Addr_reg;
  wire bcTakenHit = bcHit && bcState[bcIdx][1];
  // Fetch-two word: live bus data, or the copy held across a stall
  wire [31:0] s2Word = s2Live_reg ? busData : s2Hold_reg;
  // Early decode of the returned word
  wire [7:0] opc = s2Word[31:24];
  wire [31:0] disp = {{8{s2Word[23]}}, s2Word[23:0]};
  reg [2:0] dClass;
  always @*
  begin
    case (opc)
      `OPC_COND: dClass = `CLASS_COND;
      `OPC_UNCOND: dClass = `CLASS_UNCOND;
      `OPC_CALL: dClass = `CLASS_CALL;
      `OPC_RET: dClass = `CLASS_RET;
      default: dClass = `CLASS_SEQ;
    endcase
  end
  // (RULE10) Second level consulted when the cache gave no taken hit
  wire [6:0] ptIdx = s2Addr_reg[8:2];
  wire ptTaken = ptState[ptIdx][1];
  wire condTaken = s2Hit_reg ? 1'b1 : ptTaken;
  wire [31:0] relTarget = s2Addr_reg + disp;
  wire [31:0] retAddr = s2Addr_reg + `FETCH_STEP;
  // Redirect from fetch two when no cached target was used
  reg edRedirect;
  reg [31:0] edTarget;
  always @*
  begin
    edRedirect = 1'b0;
    edTarget = relTarget;
    if (s2Valid_reg && !s2Hit_reg)
    begin
      case (dClass)
        // (RULE11) Predicted taken, target computed
        `CLASS_COND: edRedirect = ptTaken;
        // (RULE12) Unconditional and call targets
        `CLASS_UNCOND, `CLASS_CALL: edRedirect = 1'b1;
        // (RULE13) Return uses stacked address
        `CLASS_RET:
        begin
          edRedirect = rsCount_reg != 3'h0;
          edTarget = rstack[rsTop_reg];
        end
        default: edRedirect = 1'b0;
      endcase
    end
  end

  // Buffer and decode-stage handshake
  wire [1:0] take = {decodeTake[1] & valid1, decodeTake[0] & valid0};
  wire [1:0] nTake = {1'b0, take[0]} + {1'b0, take[1]};
  // Read pointer and count as they stand after this cycle's take
  localparam [3:0] LAST_SLOT = DEPTH - 1;
  wire [3:0] cntLeft = bufCnt_reg - {2'h0, nTake};
  wire [3:0] rdOne = bufRd_reg == LAST_SLOT ? 4'h0 : bufRd_reg + 4'h1;
  wire [3:0] rdTwo = rdOne == LAST_SLOT ? 4'h0 : rdOne + 4'h1;
  wire [3:0] rdNext = nTake == 2'h2 ? rdTwo :
    (nTake == 2'h1 ? rdOne : bufRd_reg);
  wire [3:0] rdAfter = rdNext == LAST_SLOT ? 4'h0 : rdNext + 4'h1;
  assign bufFull = bufCnt_reg >= DEPTH - 2;
  assign bufEmpty = bufCnt_reg == 4'h0;
  // (RULE9) Folded taken conditional branch is dropped from the stream
  wire fold = edClass_reg == `CLASS_COND && edTaken_reg && edHit_reg;
  wire stall = bufFull;
  // A stalled early-decode word is held, so it is pushed only once
  wire pushEd = edValid_reg && !fold && !stall;
  wire flush = resolveValid && resolveMispredict;
  // (RULE2) Bus access started at fetch one
  assign busReq = s1Valid_reg && !stall;
  always @*
  begin
    busAddr = s1Addr_reg;
  end

  // (RULE1) Pipeline stage advance
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      agAddr_reg <= `RESET_FETCH_ADDR;
      s1Valid_reg <= 1'b0;
      s2Valid_reg <= 1'b0;
      edValid_reg <= 1'b0;
      s1Addr_reg <= `RESET_FETCH_ADDR;
      s2Addr_reg <= `RESET_FETCH_ADDR;
      edAddr_reg <= `RESET_FETCH_ADDR;
      edInstr_reg <= 32'h0000_0000;
      edClass_reg <= `CLASS_SEQ;
      edTaken_reg <= 1'b0;
      s2Hit_reg <= 1'b0;
      edHit_reg <= 1'b0;
      rsTop_reg <= 2'h0;
      rsCount_reg <= 3'h0;
    end
    else if (flush)
    begin
      agAddr_reg <= resolveTarget;
      s1Valid_reg <= 1'b0;
      s2Valid_reg <= 1'b0;
      edValid_reg <= 1'b0;
    end
    else if (!stall)
    begin
      s1Valid_reg <= 1'b1;
      s1Addr_reg <= agAddr_reg;
      // (RULE8) Cache target fed back from fetch one
      if (edRedirect)
        agAddr_reg <= edTarget;
      else if (bcTakenHit)
        agAddr_reg <= bcTarget[bcIdx];
      else
        agAddr_reg <= agAddr_reg + `FETCH_STEP;
      // (RULE2) Access completes at fetch two
      s2Valid_reg <= s1Valid_reg && !edRedirect;
      s2Addr_reg <= s1Addr_reg;
      s2Hit_reg <= bcTakenHit;
      // Wrong-path word behind a redirect or a taken cache hit is dropped
      if (edRedirect || bcTakenHit)
        s1Valid_reg <= 1'b0;
      // (RULE3) Decode signals travel with instruction
      edValid_reg <= s2Valid_reg;
      edAddr_reg <= s2Addr_reg;
      edInstr_reg <= s2Word;
      edHit_reg <= s2Hit_reg;
      edClass_reg <= dClass;
      edTaken_reg <= dClass == `CLASS_COND ? condTaken : edRedirect;
      // (RULE13) Push on call, pop on return
      if (s2Valid_reg && dClass == `CLASS_CALL)
      begin
        rsTop_reg <= rsTop_reg + 2'h1;
        if (rsCount_reg != 3'h4)
          rsCount_reg <= rsCount_reg + 3'h1;
      end
      else if (s2Valid_reg && dClass == `CLASS_RET && rsCount_reg != 3'h0)
      begin
        rsTop_reg <= rsTop_reg - 2'h1;
        rsCount_reg <= rsCount_reg - 3'h1;
      end
    end
  end

  // Hold the fetch-two word, since the bus answers only once
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s2Live_reg <= 1'b0;
      s2Hold_reg <= 32'h0000_0000;
    end
    else
    begin
      s2Live_reg <= !flush && !stall;
      s2Hold_reg <= s2Word;
    end
  end

  // Return stack storage
  always @(posedge clock)
  begin
    if (!flush && !stall && s2Valid_reg && dClass == `CLASS_CALL)
      rstack[rsTop_reg + 2'h1] <= retAddr;
  end

  // (RULE4) Ten-entry FIFO between fetch and decode
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bufRd_reg <= 4'h0;
      bufWr_reg <= 4'h0;
      bufCnt_reg <= 4'h0;
    end
    else if (flush)
    begin
      bufRd_reg <= 4'h0;
      bufWr_reg <= 4'h0;
      bufCnt_reg <= 4'h0;
    end
    else
    begin
      if (pushEd)
      begin
        bufInstr[bufWr_reg] <= edInstr_reg;
        bufPc[bufWr_reg] <= edAddr_reg;
        bufClass[bufWr_reg] <= edClass_reg;
        bufTaken[bufWr_reg] <= edTaken_reg;
        bufWr_reg <= bufWr_reg == DEPTH - 1 ? 4'h0 : bufWr_reg + 4'h1;
      end
      bufRd_reg <= rdNext;
      bufCnt_reg <= bufCnt_reg + {3'h0, pushEd} - {2'h0, nTake};
    end
  end

  // (RULE5) Decode slots load from buffer, else bypass from early decode
  wire bypass = pushEd && cntLeft == 4'h0;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid0 <= 1'b0;
      valid1 <= 1'b0;
      instr0 <= 32'h0000_0000;
      pc0 <= 32'h0000_0000;
      class0 <= `CLASS_SEQ;
      taken0 <= 1'b0;
      instr1 <= 32'h0000_0000;
      pc1 <= 32'h0000_0000;
      class1 <= `CLASS_SEQ;
      taken1 <= 1'b0;
    end
    else if (flush)
    begin
      valid0 <= 1'b0;
      valid1 <= 1'b0;
    end
    else if (bypass)
    begin
      valid0 <= 1'b1;
      instr0 <= edInstr_reg;
      pc0 <= edAddr_reg;
      class0 <= edClass_reg;
      taken0 <= edTaken_reg;
      valid1 <= 1'b0;
    end
    else
    begin
      // Slots show the entries left after this cycle's take
      valid0 <= cntLeft != 4'h0;
      instr0 <= bufInstr[rdNext];
      pc0 <= bufPc[rdNext];
      class0 <= bufClass[rdNext];
      taken0 <= bufTaken[rdNext];
      valid1 <= cntLeft > 4'h1;
      instr1 <= bufInstr[rdAfter];
      pc1 <= bufPc[rdAfter];
      class1 <= bufClass[rdAfter];
      taken1 <= bufTaken[rdAfter];
    end
  end

  // (RULE6) (RULE7) (RULE15) Cache and table training on resolve
  wire [2:0] rIdx = resolvePc[4:2];
  wire [6:0] rPt = resolvePc[8:2];
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bcValid <= 8'h00;
      for (i = 0; i < `PRED_TABLE_ENTRIES; i = i + 1)
        ptState[i] <= `PRED_WEAK_NT;
      for (i = 0; i < `BRANCH_CACHE_ENTRIES; i = i + 1)
      begin
        bcState[i] <= `PRED_WEAK_NT;
        bcBranch[i] <= 32'h0000_0000;
        bcTarget[i] <= 32'h0000_0000;
      end
    end
    else if (resolveValid)
    begin
      // (RULE15) Saturating step toward outcome
      if (resolveTaken && ptState[rPt] != `PRED_STRONG_T)
        ptState[rPt] <= ptState[rPt] + 2'h1;
      else if (!resolveTaken && ptState[rPt] != `PRED_STRONG_NT)
        ptState[rPt] <= ptState[rPt] - 2'h1;
      if (bcValid[rIdx] && bcBranch[rIdx] == resolvePc)
      begin
        if (resolveTaken && bcState[rIdx] != `PRED_STRONG_T)
          bcState[rIdx] <= bcState[rIdx] + 2'h1;
        else if (!resolveTaken && bcState[rIdx] != `PRED_STRONG_NT)
          bcState[rIdx] <= bcState[rIdx] - 2'h1;
      end
      else if (resolveTaken)
      begin
        // (RULE7) Allocate branch and target pair
        bcValid[rIdx] <= 1'b1;
        bcBranch[rIdx] <= resolvePc;
        bcTarget[rIdx] <= resolveTarget;
        bcState[rIdx] <= `PRED_WEAK_T;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/fetch_program.svh
// Test program image shared by the memory model and the bench
function automatic logic [31:0] progWord(input logic [31:0] a);
  case (a)
    32'h0000_0040: progWord = {`OPC_UNCOND, 24'h00_0030};
    32'h0000_0104: progWord = {`OPC_COND, 24'h00_0010};
    32'h0000_0140: progWord = {`OPC_CALL, 24'h00_0030};
    32'h0000_0220: progWord = {`OPC_RET, 24'h00_0000};
    default: progWord = {8'h00, a[25:2]};
  endcase
endfunction

// ### testbench/fetch_checker_properties.sv
// Port checker for the fetch front end
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pipeline_regs.vh"
module fetch_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Observed ports
  input wire logic [31:0] busAddr,
  input wire logic busReq,
  input wire logic [31:0] instr0,
  input wire logic [31:0] pc0,
  input wire logic [2:0] class0,
  input wire logic valid0,
  input wire logic [31:0] pc1,
  input wire logic valid1,
  input wire logic [1:0] decodeTake,
  input wire logic resolveValid,
  input wire logic [31:0] resolveTarget,
  input wire logic resolveMispredict,
  input wire logic bufFull,
  input wire logic bufEmpty
);
  logic [31:0] redirTarget;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Expected class from the opcode byte
  function automatic logic [2:0] cls(input logic [7:0] op);
    case (op)
      `OPC_COND: cls = `CLASS_COND;
      `OPC_UNCOND: cls = `CLASS_UNCOND;
      `OPC_CALL: cls = `CLASS_CALL;
      `OPC_RET: cls = `CLASS_RET;
      default: cls = `CLASS_SEQ;
    endcase
  endfunction
  // Latest restart address after a mispredict
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      redirTarget <= 32'h0000_0000;
    else if (resolveValid && resolveMispredict)
      redirTarget <= resolveTarget;
  end
  a_reset_start: assert property ($rose(rst_n) |-> ##[0:4]
    (busReq && busAddr == `RESET_FETCH_ADDR)) else $error("no first fetch");
  a_full_stalls: assert property (bufFull |-> !busReq)
    else $error("fetch while full");
  a_full_empty: assert property (!(bufFull && bufEmpty))
    else $error("full and empty");
  a_slot_pair: assert property (valid1 && class0 == `CLASS_SEQ |->
    valid0 && pc1 == pc0 + `FETCH_STEP) else $error("slot1 not next");
  a_class_decode: assert property (valid0 |->
    class0 == cls(instr0[31:24])) else $error("wrong class");
  a_fetch_aligned: assert property (busReq |-> busAddr[1:0] == 2'b00)
    else $error("unaligned fetch");
  a_flush_slots: assert property (resolveValid && resolveMispredict
    |=> !valid0 && !valid1) else $error("slots kept after flush");
  a_restart_addr: assert property (resolveValid && resolveMispredict
    |=> ##[0:6] (busReq && busAddr == redirTarget)) else $error("no restart");
  a_take_advances: assert property (valid0 && decodeTake[0] |=>
    !valid0 || pc0 != $past(pc0)) else $error("taken slot stood");
  c_full: cover property (bufFull);
  c_dual: cover property (valid1 && decodeTake == 2'b11);
  c_call: cover property (valid0 && class0 == `CLASS_CALL);
endmodule
`default_nettype wire

// ### testbench/instr_memory_model.sv
// Instruction memory behind the local instruction bus
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pipeline_regs.vh"
module instr_memory_model (
  // Clock
  input wire logic clock,
  // Bus
  input wire logic busReq,
  input wire logic [31:0] busAddr,
  output logic [31:0] busData
);
  `include "fetch_program.svh"
  initial busData = 32'h0000_0000;
  // Answer one cycle after the request; scramble when idle
  // next cycle data
  always @(posedge clock)
  begin
    if (busReq)
      busData <= progWord(busAddr);
    else
      busData <= ~busData;
  end
endmodule
`default_nettype wire

// ### testbench/instr_fetch_branch_predictor_bench.sv
// Self-checking bench for the fetch front end
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pipeline_regs.vh"
module instr_fetch_branch_predictor_bench;
  `include "fetch_program.svh"
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] busAddr, busData, instr0, pc0, instr1, pc1, expPc;
  logic [2:0] class0, class1;
  logic busReq, taken0, valid0, taken1, valid1, bufFull, bufEmpty;
  logic [1:0] decodeTake = 2'b00;
  logic resolveValid = 1'b0;
  logic resolveTaken = 1'b0;
  logic resolveMispredict = 1'b0;
  logic [31:0] resolvePc = 32'h0000_0000;
  logic [31:0] resolveTarget = 32'h0000_0000;
  logic [15:0] lfsr = 16'h993D;
  logic [31:0] retStack[$];
  logic takeOn = 1'b0;
  logic kick = 1'b0;
  int fail_count = 0;
  int checks = 0;
  int consumed = 0;
  int i;
  int j;
  initial expPc = `RESET_FETCH_ADDR;
  initial forever #12.5 clock = ~clock;
  instr_fetch_branch_predictor i_instr_fetch_branch_predictor (.clock,
    .rst_n, .busAddr, .busReq, .busData, .instr0, .pc0, .class0, .taken0,
    .valid0, .instr1, .pc1, .class1, .taken1, .valid1, .decodeTake,
    .resolveValid, .resolvePc, .resolveTarget, .resolveTaken,
    .resolveMispredict, .bufFull, .bufEmpty);
  instr_memory_model i_instr_memory_model (.clock, .busReq, .busAddr,
    .busData);
  task automatic checkVal(input string name, input logic [31:0] seen,
    input logic [31:0] expv);
  begin
    checks++;
    if (seen !== expv)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, expv, seen);
    end
  end
  endtask
  // Next random word
  function automatic logic [15:0] lfsrNext(input logic [15:0] v);
    lfsrNext = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Compare one consumed slot and step the expected flow
  task automatic consume(input logic [31:0] pc, input logic [31:0] w,
    input logic t);
    logic expTaken;
  begin
    expTaken = w[31:24] == `OPC_UNCOND || w[31:24] == `OPC_CALL ||
      (w[31:24] == `OPC_RET && retStack.size() > 0);
    checkVal("pc", pc, expPc);
    checkVal("taken", t, expTaken);
    checkVal("instr", w, progWord(expPc));
    consumed++;
    if (w[31:24] == `OPC_CALL)
      retStack.push_back(expPc + `FETCH_STEP);
    if (w[31:24] == `OPC_RET && retStack.size() > 0)
      expPc = retStack.pop_back();
    else if (w[31:24] == `OPC_CALL || w[31:24] == `OPC_UNCOND)
      expPc = expPc + {{8{w[23]}}, w[23:0]};
    else
      expPc = expPc + `FETCH_STEP;
  end
  endtask
  // Random consumer and training traffic, plus the mispredict pulse
  always @(posedge clock)
  begin
    if (valid0 === 1'b1 && decodeTake[0] === 1'b1)
    begin
      consume(pc0, instr0, taken0);
      if (valid1 === 1'b1 && decodeTake[1] === 1'b1)
        consume(pc1, instr1, taken1);
    end
    lfsr = lfsrNext(lfsr);
    decodeTake <= !takeOn ? 2'b00 : (lfsr[1:0] == 2'b00 ? 2'b00 :
      (lfsr[1] ? 2'b11 : 2'b01));
    resolveValid <= kick | (takeOn & lfsr[5] & lfsr[6]);
    resolveMispredict <= kick;
    // Training stays off the table entry of the program's conditional
    resolvePc <= {16'h8000, lfsr[15:5], 1'b1, lfsr[3:0]};
    resolveTaken <= lfsr[7];
    resolveTarget <= kick ? 32'h0000_0400 : {16'h8001, lfsr};
    if (kick)
    begin
      expPc = 32'h0000_0400;
      kick = 1'b0;
    end
  end
  task automatic report_and_stop;
  begin
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    takeOn = 1'b1;
    repeat (400) @(negedge clock);
    checkVal("progress", consumed > 40, 1'b1);
    takeOn = 1'b0;
    for (i = 0; i < 80 && bufFull !== 1'b1; i++)
      @(negedge clock);
    checkVal("full", bufFull, 1'b1);
    checkVal("empty", bufEmpty, 1'b0);
    checkVal("halt", busReq, 1'b0);
    kick = 1'b1;
    repeat (3) @(negedge clock);
    i = consumed;
    takeOn = 1'b1;
    for (j = 0; j < 400 && consumed < i + 20; j++)
      @(negedge clock);
    checkVal("restart", consumed >= i + 20, 1'b1);
    report_and_stop();
  end
  // Hard stop for a hang
  initial
  begin
    #(25 * 5000);
    fail_count++;
    report_and_stop();
  end
endmodule
bind instr_fetch_branch_predictor fetch_checker i_fetch_checker (.clock,
  .rst_n, .busAddr, .busReq, .instr0, .pc0, .class0, .valid0, .pc1,
  .valid1, .decodeTake, .resolveValid, .resolveTarget, .resolveMispredict,
  .bufFull, .bufEmpty);
`default_nettype wire
